// ---- src/alu_subtract_skip_map.vh ----
// Purpose: Constants for the subtract, skip and bit execution block
// Assumes: 8-bit data path, 8-entry data memory of flip-flops
// Notes:   Opcodes are local encodings of the operation select port
`ifndef ALU_SUBTRACT_SKIP_MAP_VH
`define ALU_SUBTRACT_SKIP_MAP_VH

`define DATA_W        8
`define OP_W          4
`define MEM_AW        3
`define MEM_DEPTH     8
`define BIT_SEL_W     3
`define FLAG_W        4

// Operation codes
`define OP_NOP        4'h0
`define OP_RRC_ACC    4'h1
`define OP_SBC_ACC    4'h2
`define OP_SBC_MEM    4'h3
`define OP_SUB_ACC    4'h4
`define OP_SUB_MEM    4'h5
`define OP_SUB_IMM    4'h6
`define OP_DEC_SKIP   4'h7
`define OP_DEC_ACC    4'h8
`define OP_INC_SKIP   4'h9
`define OP_INC_ACC    4'hA
`define OP_SET_BYTE   4'hB
`define OP_SET_BIT    4'hC
`define OP_BIT_SKIP   4'hD
`define OP_SWAP       4'hE

// Flag vector layout {ov, z, ac, c}
`define FLAG_C        0
`define FLAG_AC       1
`define FLAG_Z        2
`define FLAG_OV       3

// Reset values and byte constants
`define ACC_RST       8'h00
`define MEM_RST       8'h00
`define FLAGS_RST     4'h0
`define ALL_ONES      8'hFF
`define ONE_BYTE      8'h01
`define ZERO_BYTE     8'h00

// Bus answer for an unmapped address
`define BUS_BAD_DATA  32'h00000000

// Register word addresses (byte offset / 4)
`define REG_ACC       4'h0
`define REG_FLAGS     4'h1
`define REG_CMD       4'h2
`define REG_STATUS    4'h3
`define REG_MEM_BASE  4'h8
`define REG_ADDR_W    4

// Command register fields
`define CMD_OP_LSB    0
`define CMD_OP_MSB    3
`define CMD_ADDR_LSB  4
`define CMD_ADDR_MSB  6
`define CMD_BIT_LSB   8
`define CMD_BIT_MSB   10
`define CMD_IMM_LSB   16
`define CMD_IMM_MSB   23

// Execution states
`define ST_W          2
`define ST_IDLE       2'h0
`define ST_EXEC       2'h1
`define ST_DUMMY      2'h2

`endif

// ---- src/alu_core.v ----
// Purpose: Combinational arithmetic for one operation
// Assumes: Operands stable while the operation is presented
// Notes:   Pure function of inputs, no state
`timescale 1ns/1ps
`include "alu_subtract_skip_map.vh"
module alu_core (
  input  wire [`OP_W-1:0]      op_i,
  input  wire [`DATA_W-1:0]    acc_i,
  input  wire [`DATA_W-1:0]    mem_i,
  input  wire [`DATA_W-1:0]    imm_i,
  input  wire [`BIT_SEL_W-1:0] bit_i,
  input  wire [`FLAG_W-1:0]    flags_i,
  output reg  [`DATA_W-1:0]    result_o,
  output reg  [`FLAG_W-1:0]    flags_o,
  output reg                   to_acc_o,
  output reg                   to_mem_o,
  output reg                   skip_o
);

  reg  [`DATA_W-1:0] sub_b;
  reg                sub_cin;
  reg  [`DATA_W:0]   sum;
  reg  [4:0]         low_sum;
  reg  [`DATA_W-1:0] bit_mask;
  reg  [`DATA_W-1:0] dec_v;
  reg  [`DATA_W-1:0] inc_v;

  always @* begin
    sub_b    = (op_i == `OP_SUB_IMM) ? ~imm_i : ~mem_i;
    sub_cin  = flags_i[`FLAG_C];
    if (op_i == `OP_SUB_ACC || op_i == `OP_SUB_MEM ||
        op_i == `OP_SUB_IMM) begin
      sub_cin = 1'b1;
    end
    sum      = {1'b0, acc_i} + {1'b0, sub_b} + {8'h00, sub_cin};
    low_sum  = {1'b0, acc_i[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_cin};
    bit_mask = `ONE_BYTE << bit_i;
    dec_v    = mem_i - `ONE_BYTE;
    inc_v    = mem_i + `ONE_BYTE;
    result_o = `ZERO_BYTE;
    flags_o  = flags_i;
    to_acc_o = 1'b0;
    to_mem_o = 1'b0;
    skip_o   = 1'b0;
    case (op_i)
      `OP_RRC_ACC: begin
        result_o = {flags_i[`FLAG_C], mem_i[7:1]};
        flags_o[`FLAG_C] = mem_i[0];
        to_acc_o = 1'b1;
      end
      `OP_SBC_ACC, `OP_SBC_MEM, `OP_SUB_ACC, `OP_SUB_MEM,
      `OP_SUB_IMM: begin
        result_o = sum[7:0];
        // Carry set means no borrow
        flags_o[`FLAG_C]  = sum[8];
        flags_o[`FLAG_AC] = low_sum[4];
        flags_o[`FLAG_Z]  = (sum[7:0] == `ZERO_BYTE);
        flags_o[`FLAG_OV] = (acc_i[7] == sub_b[7]) &&
                            (sum[7] != acc_i[7]);
        to_mem_o = (op_i == `OP_SBC_MEM) || (op_i == `OP_SUB_MEM);
        to_acc_o = ~to_mem_o;
      end
      `OP_DEC_SKIP: begin
        result_o = dec_v;
        to_mem_o = 1'b1;
        skip_o   = (dec_v == `ZERO_BYTE);
      end
      `OP_DEC_ACC: begin
        result_o = dec_v;
        to_acc_o = 1'b1;
        skip_o   = (dec_v == `ZERO_BYTE);
      end
      `OP_INC_SKIP: begin
        result_o = inc_v;
        to_mem_o = 1'b1;
        skip_o   = (inc_v == `ZERO_BYTE);
      end
      `OP_INC_ACC: begin
        result_o = inc_v;
        to_acc_o = 1'b1;
        skip_o   = (inc_v == `ZERO_BYTE);
      end
      `OP_SET_BYTE: begin
        result_o = `ALL_ONES;
        to_mem_o = 1'b1;
      end
      `OP_SET_BIT: begin
        result_o = mem_i | bit_mask;
        to_mem_o = 1'b1;
      end
      `OP_BIT_SKIP: begin
        skip_o = |(mem_i & bit_mask);
      end
      `OP_SWAP: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        to_mem_o = 1'b1;
      end
      default: begin
        result_o = `ZERO_BYTE;
      end
    endcase
  end

endmodule // alu_core

// ---- src/alu_subtract_skip_ops.v ----
// Contract
// - Rotate right through carry into accumulator
// - Subtract with borrow, to accumulator or memory
// - Subtract memory byte, to accumulator or memory
// - Subtract immediate byte into accumulator
// - True skip adds one dummy cycle
// - Decrement memory, skip if zero
// - Decrement into accumulator, skip if zero
// - Increment memory, skip if zero
// - Increment into accumulator, skip if zero
// - Set whole memory byte to ones
// - Set selected memory bit only
// - Skip when selected bit is set
// - Swap memory byte nibbles in place
//
// Purpose: Execution unit for subtract, skip and bit operations
// Assumes: Avalon-MM slave, 32-bit data, word addresses
// Notes:   Writing the command word starts one operation
`timescale 1ns/1ps
`include "alu_subtract_skip_map.vh"
module alu_subtract_skip_ops (
  input  wire                   clk_i,
  input  wire                   sys_rst_i,
  input  wire [`REG_ADDR_W-1:0] avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  input  wire [3:0]             avs_byteenable_i,
  output reg  [31:0]            avs_readdata_o,
  output reg                    avs_waitrequest_o,
  output reg                    busy_o,
  output reg                    skip_o,
  output reg  [`DATA_W-1:0]     acc_o,
  output reg  [`FLAG_W-1:0]     flags_o
);

  reg  [`ST_W-1:0]      state_q;
  reg  [`OP_W-1:0]      op_q;
  reg  [`MEM_AW-1:0]    addr_q;
  reg  [`BIT_SEL_W-1:0] bit_q;
  reg  [`DATA_W-1:0]    imm_q;
  reg  [`DATA_W-1:0]    mem_q [0:`MEM_DEPTH-1];
  reg                   ack_q;
  reg  [`DATA_W-1:0]    mem_rd;
  wire [`DATA_W-1:0]    res;
  wire [`FLAG_W-1:0]    flags_nx;
  wire                  to_acc;
  wire                  to_mem;
  wire                  skip_now;
  wire                  req;
  wire                  mem_sel;
  wire [`MEM_AW-1:0]    bus_idx;
  wire                  cmd_wr;
  wire                  exec;
  genvar                gi;

  assign req     = (avs_read_i | avs_write_i) & ~ack_q;
  assign mem_sel = avs_address_i[3];
  assign bus_idx = avs_address_i[`MEM_AW-1:0];
  // Command start refused while an operation runs
  assign cmd_wr  = req & avs_write_i & (avs_address_i == `REG_CMD) &
                   (state_q == `ST_IDLE) & avs_byteenable_i[0];
  assign exec    = (state_q == `ST_EXEC);

  always @* begin
    mem_rd = mem_q[addr_q];
  end

  alu_core alu_core_inst (
    .op_i     (op_q),
    .acc_i    (acc_o),
    .mem_i    (mem_rd),
    .imm_i    (imm_q),
    .bit_i    (bit_q),
    .flags_i  (flags_o),
    .result_o (res),
    .flags_o  (flags_nx),
    .to_acc_o (to_acc),
    .to_mem_o (to_mem),
    .skip_o   (skip_now)
  );

  // Bus handshake: one wait cycle, then acknowledge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      ack_q             <= req;
      avs_waitrequest_o <= ~req;
      if (req & avs_read_i) begin
        if (mem_sel) begin
          avs_readdata_o <= {24'h000000, mem_q[bus_idx]};
        end else begin
          case (avs_address_i)
            `REG_ACC:    avs_readdata_o <= {24'h000000, acc_o};
            `REG_FLAGS:  avs_readdata_o <= {28'h0000000, flags_o};
            `REG_CMD:    avs_readdata_o <= {8'h00, imm_q, 5'h00,
                                            bit_q, 1'b0, addr_q, op_q};
            `REG_STATUS: avs_readdata_o <= {30'h00000000, skip_o,
                                            busy_o};
            default:     avs_readdata_o <= `BUS_BAD_DATA;
          endcase
        end
      end
    end
  end

  // Sequencer: idle, execute, optional dummy cycle
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q     <= `ST_IDLE;
      op_q        <= `OP_NOP;
      addr_q      <= {`MEM_AW{1'b0}};
      bit_q       <= {`BIT_SEL_W{1'b0}};
      imm_q       <= `ZERO_BYTE;
      busy_o      <= 1'b0;
      skip_o      <= 1'b0;
    end else begin
      case (state_q)
        `ST_IDLE: begin
          if (cmd_wr) begin
            op_q    <= avs_writedata_i[`CMD_OP_MSB:`CMD_OP_LSB];
            addr_q  <= avs_writedata_i[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            bit_q   <= avs_writedata_i[`CMD_BIT_MSB:`CMD_BIT_LSB];
            imm_q   <= avs_writedata_i[`CMD_IMM_MSB:`CMD_IMM_LSB];
            busy_o  <= 1'b1;
            skip_o  <= 1'b0;
            state_q <= `ST_EXEC;
          end
        end
        `ST_EXEC: begin
          skip_o      <= skip_now;
          if (skip_now) begin
            // Prefetched instruction is dropped here
            state_q <= `ST_DUMMY;
          end else begin
            busy_o  <= 1'b0;
            state_q <= `ST_IDLE;
          end
        end
        `ST_DUMMY: begin
          busy_o  <= 1'b0;
          state_q <= `ST_IDLE;
        end
        default: begin
          state_q <= `ST_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  // Accumulator and flags; ops without flag effect keep flags
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_o   <= `ACC_RST;
      flags_o <= `FLAGS_RST;
    end else if (exec) begin
      if (to_acc) begin
        acc_o <= res;
      end
      flags_o <= flags_nx;
    end else if (req & avs_write_i & ~mem_sel &
                 (state_q == `ST_IDLE) & avs_byteenable_i[0]) begin
      if (avs_address_i == `REG_ACC) begin
        acc_o <= avs_writedata_i[`DATA_W-1:0];
      end
      if (avs_address_i == `REG_FLAGS) begin
        flags_o <= avs_writedata_i[`FLAG_W-1:0];
      end
    end
  end

  // Data memory entries; results write back only in execute
  generate
    for (gi = 0; gi < `MEM_DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          mem_q[gi] <= `MEM_RST;
        end else if (exec & to_mem & (addr_q == gi)) begin
          mem_q[gi] <= res;
        end else if (req & avs_write_i & mem_sel & avs_byteenable_i[0] &
                     (state_q == `ST_IDLE) & (bus_idx == gi)) begin
          mem_q[gi] <= avs_writedata_i[`DATA_W-1:0];
        end
      end
    end
  endgenerate

endmodule // alu_subtract_skip_ops

// ---- bench/alu_subtract_skip_ops_sva.sv ----
// Purpose: Port checks for the subtract, skip and bit block
// Assumes: One clock, command word at word address 2
// Notes:   Results are looked at two edges after a command is taken
`timescale 1ns/1ps
module alu_subtract_skip_ops_sva (
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic [3:0]  avs_address_i,
  input logic        avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0]  avs_byteenable_i,
  input logic        avs_waitrequest_o,
  input logic        busy_o,
  input logic        skip_o,
  input logic [7:0]  acc_o,
  input logic [3:0]  flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [3:0] op  = avs_writedata_i[3:0];
  wire [7:0] imm = avs_writedata_i[23:16];
  // Held request is seen twice; only the unanswered edge counts
  sequence go;
    avs_write_i && avs_address_i == 4'h2 && avs_byteenable_i[0]
      && avs_waitrequest_o && !busy_o;
  endsequence
  a_skip_dummy: assert property (
    go ##2 skip_o |-> busy_o ##1 !busy_o)
    else $error("Skip did not add exactly one dummy cycle");
  a_noskip_one: assert property (
    go ##2 !skip_o |-> !busy_o)
    else $error("Op without skip held busy too long");
  a_flags_keep: assert property (
    go ##0 op inside {[4'h7:4'hD]} |-> ##2 flags_o == $past(flags_o, 2))
    else $error("Flags moved on an op that keeps them");
  a_rrc_carry: assert property (
    go ##0 op == 4'h1 |-> ##2 acc_o[7] == $past(flags_o[0], 2)
      && flags_o[3:1] == $past(flags_o[3:1], 2))
    else $error("Rotate did not carry old carry into bit 7");
  a_sub_zero: assert property (
    go ##0 op inside {4'h2, 4'h4, 4'h6} |-> ##2
      flags_o[2] == (acc_o == 8'h00))
    else $error("Zero flag disagrees with result");
  a_imm_result: assert property (
    go ##0 op == 4'h6 |-> ##2 acc_o == $past(acc_o, 2) - $past(imm, 2)
      && flags_o[0] == ($past(acc_o, 2) >= $past(imm, 2)))
    else $error("Immediate subtract result or carry wrong");
  a_imm_ovf: assert property (
    go ##0 op == 4'h6 |-> ##2 flags_o[3] == (($past(acc_o[7], 2)
      ^ $past(imm[7], 2)) & ($past(acc_o[7], 2) ^ acc_o[7])))
    else $error("Overflow flag wrong on immediate subtract");
  a_skip_acc: assert property (
    go ##0 op inside {4'h8, 4'hA} |-> ##2 skip_o == (acc_o == 8'h00))
    else $error("Skip disagrees with accumulator result");
endmodule // alu_subtract_skip_ops_sva

// ---- bench/alu_subtract_skip_ops_test.sv ----
// Purpose: Self-checking bench for the subtract, skip and bit block
// Assumes: Bus answers after one wait cycle, command at word 2
// Notes:   Reference model tracks accumulator, flags and memory
`timescale 1ns/1ps
module alu_subtract_skip_ops_test;
  logic        clk_i, sys_rst_i, avs_read_i, avs_write_i, k;
  logic [3:0]  avs_address_i, avs_byteenable_i, flags_o, ef, op;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic        avs_waitrequest_o, busy_o, skip_o, ci, h;
  logic [7:0]  acc_o, ea, m, y, r, em [0:7];
  logic [8:0]  s;
  logic [2:0]  a, b;
  int          fails, compares, i, n;
  // {op, addr, bit, imm}: wraps, borrows and overflow first
  logic [19:0] tbl [0:21] = '{20'h40000, 20'h6007F, 20'h27000,
    20'h27000, 20'h35000, 20'h54000, 20'h16000, 20'h17000, 20'h70000,
    20'h71000, 20'h91000, 20'h90000, 20'h80000, 20'hA2000, 20'hA3000,
    20'h82000, 20'hB6000, 20'hC3000, 20'hC3000, 20'hD3000, 20'hD3100,
    20'hE4000};
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task wrap_up;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp) begin
        fails++;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    begin
      n = 0;
      avs_address_i   <= ad;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 20) begin
        @(posedge clk_i);
        n++;
      end
      // A slave that never answers counts against the run
      if (n >= 20) fails++;
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task step(input logic [19:0] t);
    begin
      op = t[19:16];
      a  = t[14:12];
      b  = t[10:8];
      m  = em[a];
      y  = (op == 4'h6) ? t[7:0] : m;
      ci = (op == 4'h2 || op == 4'h3) ? ef[0] : 1'b1;
      s  = {1'b0, ea} + {1'b0, ~y} + ci;
      h  = ({1'b0, ea[3:0]} + {1'b0, ~y[3:0]} + ci) >> 4;
      r  = s[7:0];
      case (op)
        4'h1: begin
          ea    = {ef[0], m[7:1]};
          ef[0] = m[0];
        end
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
          ef = {(ea[7] ^ y[7]) & (ea[7] ^ r[7]), r == 8'h00, h, s[8]};
          if (op == 4'h3 || op == 4'h5) em[a] = r;
          else ea = r;
        end
        4'h7: em[a] = m - 8'h01;
        4'h8: ea = m - 8'h01;
        4'h9: em[a] = m + 8'h01;
        4'hA: ea = m + 8'h01;
        4'hB: em[a] = 8'hFF;
        4'hC: em[a][b] = 1'b1;
        4'hE: em[a] = {m[3:0], m[7:4]};
        default: ;
      endcase
      k = (op == 4'h7 || op == 4'h9) ? em[a] == 8'h00 :
          (op == 4'h8 || op == 4'hA) ? ea == 8'h00 : op == 4'hD && m[b];
      bus(1'b1, 4'h2, {8'h00, t[7:0], 5'h00, b, 1'b0, a, op});
      chk(acc_o, ea);
      chk(flags_o, ef);
      chk(skip_o, k);
      // Busy still high here only while the dummy cycle runs
      chk(busy_o, k);
      bus(1'b0, {1'b1, a}, 32'h0);
      chk(rd, em[a]);
    end
  endtask
  initial begin
    sys_rst_i        = 1'b1;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_address_i    = 4'h0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hF;
    em = '{8'h01, 8'h00, 8'hFF, 8'h80, 8'h5A, 8'h7F, 8'h3C, 8'hA5};
    ea = 8'h80;
    ef = 4'h0;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 8; i++) bus(1'b1, {1'b1, i[2:0]}, {24'h000000, em[i]});
    bus(1'b1, 4'h0, {24'h000000, ea});
    bus(1'b1, 4'h1, {28'h0000000, ef});
    $display("preload done");
    for (i = 0; i < 22; i++) begin
      step(tbl[i]);
      $display("test %0d done", i);
    end
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, ea);
    bus(1'b0, 4'h1, 32'h0);
    chk(rd, ef);
    // Command word read back in its field layout
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, {8'h00, tbl[21][7:0], 5'h00, tbl[21][10:8], 1'b0,
             tbl[21][14:12], tbl[21][19:16]});
    bus(1'b0, 4'h3, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk(rd, 32'h0);
    $display("register reads done");
    wrap_up;
  end
  // Far above the few hundred cycles the run needs
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
  alu_subtract_skip_ops alu_subtract_skip_ops_inst (.clk_i, .sys_rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .busy_o,
    .skip_o, .acc_o, .flags_o);
endmodule // alu_subtract_skip_ops_test
bind alu_subtract_skip_ops alu_subtract_skip_ops_sva
  alu_subtract_skip_ops_sva_inst (.clk_i, .sys_rst_i, .avs_address_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
  .busy_o, .skip_o, .acc_o, .flags_o);
